// >>> logic/alu_pkg.sv
// Purpose: Constants and carriers for the byte ALU and relative branch unit.
// Assumes: APB register access, 32-bit data, one clock pclk at 25 MHz.
// Notes:   Function
package alu_pkg;
	localparam logic [11:0] OFS_CMD    = 12'h000;
	localparam logic [11:0] OFS_ACC    = 12'h004;
	localparam logic [11:0] OFS_FILE   = 12'h008;
	localparam logic [11:0] OFS_FLAGS  = 12'h00C;
	localparam logic [11:0] OFS_PC     = 12'h010;
	localparam logic [11:0] OFS_RESULT = 12'h014;
	localparam logic [11:0] OFS_STATUS = 12'h018;
	localparam int          CMD_OP_LSB   = 0;
	localparam int          CMD_DEST_BIT = 4;
	localparam int          CMD_BIT_LSB  = 5;
	localparam int          CMD_ADDR_LSB = 8;
	localparam int          CMD_LIT_LSB  = 16;
	localparam int          FLG_RIPPLE   = 0;
	localparam int          FLG_NIBBLE   = 1;
	localparam int          FLG_NULL     = 2;
	localparam logic [7:0]  ACC_RESET    = 8'h00;
	localparam logic [2:0]  FLAGS_RESET  = 3'h0;
	localparam logic [14:0] PC_RESET     = 15'h0000;
	localparam logic [6:0]  FILE_MAX     = 7'h7F;
	localparam logic [1:0]  BRANCH_CYCLES = 2'h2;

	typedef enum logic [3:0] {
		OP_IDLE,
		OP_ADD_ACC_TO_FILE,
		OP_ADD_ACC_FILE_WITH_RIPPLE,
		OP_ARITH_SHIFT_RIGHT_FILE,
		OP_FILE_BIT_CLEAR,
		OP_FILE_BIT_SET,
		OP_LITERAL_RELATIVE_JUMP,
		OP_ACCUMULATOR_RELATIVE_JUMP
	} op_e;

	typedef enum logic [1:0] {
		ST_READY,
		ST_FIRST,
		ST_IDLE_CYCLE
	} phase_e;

	// Bit 0 is the ripple flag, matching the flags register layout.
	typedef struct packed {
		logic        null_res;
		logic        nibble;
		logic        ripple;
	} flags_s;
endpackage

// >>> logic/byte_alu_branch.sv
// Purpose: Executes the byte ALU subset and relative jumps, with an APB register file.
// Assumes: Writing the command register starts one operation; pclk runs at 25 MHz.
// Notes:   File memory of 128 bytes is held here; software loads it via the file window register.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module byte_alu_branch #(
	parameter int FILE_DEPTH = 128
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		alu_pkg::op_e    op;
		alu_pkg::phase_e phase;
		logic            dest;
		logic [2:0]      bitpos;
		logic [6:0]      addr;
		logic [8:0]      lit;
		logic [7:0]      acc;
		alu_pkg::flags_s flags;
		logic [14:0]     pc;
		logic [7:0]      result;
		logic [6:0]      win_addr;
		logic [31:0]     rdata;
		logic            ready;
		logic            err;
	} state_s;

	state_s     st_r;
	state_s     st_nxt;
	logic [7:0] file_mem [FILE_DEPTH];
	logic       file_we;
	logic [6:0] file_wa;
	logic [7:0] file_wd;

	// Adds two bytes and a carry; returns {carry7, carry3, sum}.
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		return {hi[4], lo[4], hi[3:0], lo[3:0]};
	endfunction

	wire logic access = psel && penable;
	wire logic [7:0] fval = file_mem[st_r.addr];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [9:0] sum;
		logic [7:0] res;
		st_nxt  = st_r;
		file_we = 1'b0;
		file_wa = st_r.addr;
		file_wd = 8'h00;
		sum     = 10'h000;
		res     = 8'h00;
		st_nxt.ready = 1'b0;
		st_nxt.err   = 1'b0;
		if (st_r.phase == alu_pkg::ST_FIRST) begin
			st_nxt.phase = alu_pkg::ST_READY;
			unique case (st_r.op)
				alu_pkg::OP_ADD_ACC_TO_FILE,
				alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE: begin
					sum = add8(st_r.acc, fval,
						(st_r.op == alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE)
						&& st_r.flags.ripple);
					res = sum[7:0];
					st_nxt.flags.ripple   = sum[9];
					st_nxt.flags.nibble   = sum[8];
					st_nxt.flags.null_res = (res == 8'h00);
				end
				alu_pkg::OP_ARITH_SHIFT_RIGHT_FILE: begin
					res = {fval[7], fval[7:1]};
					st_nxt.flags.ripple   = fval[0];
					st_nxt.flags.null_res = (res == 8'h00);
				end
				alu_pkg::OP_FILE_BIT_CLEAR: begin
					res = fval & ~(8'h01 << st_r.bitpos);
				end
				alu_pkg::OP_FILE_BIT_SET: begin
					res = fval | (8'h01 << st_r.bitpos);
				end
				alu_pkg::OP_LITERAL_RELATIVE_JUMP: begin
					st_nxt.pc = st_r.pc + 15'h0001
						+ {{6{st_r.lit[8]}}, st_r.lit};
					st_nxt.phase = alu_pkg::ST_IDLE_CYCLE;
				end
				alu_pkg::OP_ACCUMULATOR_RELATIVE_JUMP: begin
					st_nxt.pc = st_r.pc + 15'h0001 + {7'h00, st_r.acc};
					st_nxt.phase = alu_pkg::ST_IDLE_CYCLE;
				end
				default: begin
				end
			endcase
			st_nxt.result = res;
			if (st_r.op inside {alu_pkg::OP_FILE_BIT_CLEAR, alu_pkg::OP_FILE_BIT_SET}) begin
				file_we = 1'b1;
				file_wd = res;
			end else if (st_r.op inside {alu_pkg::OP_ADD_ACC_TO_FILE,
				alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE,
				alu_pkg::OP_ARITH_SHIFT_RIGHT_FILE}) begin
				if (st_r.dest) begin
					file_we = 1'b1;
					file_wd = res;
				end else begin
					st_nxt.acc = res;
				end
			end
		end else if (st_r.phase == alu_pkg::ST_IDLE_CYCLE) begin
			st_nxt.phase = alu_pkg::ST_READY;
		end else if (access && !st_r.ready) begin
			st_nxt.ready = 1'b1;
			st_nxt.rdata = 32'h0000_0000;
			unique case (paddr)
				alu_pkg::OFS_CMD: begin
					if (pwrite) begin
						st_nxt.op     = alu_pkg::op_e'(pwdata[alu_pkg::CMD_OP_LSB +: 4]);
						st_nxt.dest   = pwdata[alu_pkg::CMD_DEST_BIT];
						st_nxt.bitpos = pwdata[alu_pkg::CMD_BIT_LSB +: 3];
						st_nxt.addr   = pwdata[alu_pkg::CMD_ADDR_LSB +: 7];
						st_nxt.lit    = pwdata[alu_pkg::CMD_LIT_LSB +: 9];
						st_nxt.phase  = alu_pkg::ST_FIRST;
					end else begin
						st_nxt.rdata = {7'h00, st_r.lit, 1'b0, st_r.addr, st_r.bitpos,
							st_r.dest, 4'(st_r.op)};
					end
				end
				alu_pkg::OFS_ACC: begin
					if (pwrite) st_nxt.acc = pwdata[7:0];
					st_nxt.rdata = {24'h000000, st_r.acc};
				end
				alu_pkg::OFS_FILE: begin
					if (pwrite) begin
						st_nxt.win_addr = pwdata[14:8];
						file_we = 1'b1;
						file_wa = pwdata[14:8];
						file_wd = pwdata[7:0];
					end
					st_nxt.rdata = {17'h00000, st_r.win_addr, file_mem[st_r.win_addr]};
				end
				alu_pkg::OFS_FLAGS: begin
					if (pwrite) st_nxt.flags = pwdata[2:0];
					st_nxt.rdata = {29'h00000000, st_r.flags};
				end
				alu_pkg::OFS_PC: begin
					if (pwrite) st_nxt.pc = pwdata[14:0];
					st_nxt.rdata = {17'h00000, st_r.pc};
				end
				alu_pkg::OFS_RESULT: st_nxt.rdata = {24'h000000, st_r.result};
				alu_pkg::OFS_STATUS: st_nxt.rdata = {30'h00000000, 2'(st_r.phase)};
				default: st_nxt.err = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r       <= '0;
			st_r.acc   <= alu_pkg::ACC_RESET;
			st_r.flags <= alu_pkg::FLAGS_RESET;
			st_r.pc    <= alu_pkg::PC_RESET;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge pclk) begin
		if (ce && file_we) begin
			file_mem[file_wa] <= file_wd;
		end
	end

	assign prdata  = st_r.rdata;
	assign pready  = st_r.ready;
	assign pslverr = st_r.err;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence jump_start;
		st_r.phase == alu_pkg::ST_FIRST && (st_r.op == alu_pkg::OP_LITERAL_RELATIVE_JUMP
			|| st_r.op == alu_pkg::OP_ACCUMULATOR_RELATIVE_JUMP);
	endsequence

	jump_two_cycles_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and jump_start) |=> st_r.phase == alu_pkg::ST_IDLE_CYCLE)
		else $error("jump did not enter the idle cycle");
	jump_literal_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_LITERAL_RELATIVE_JUMP
		|=> st_r.pc == 15'($past(st_r.pc) + 15'h0001 + {{6{$past(st_r.lit[8])}},
			$past(st_r.lit)}))
		else $error("literal jump target wrong");
	jump_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_ACCUMULATOR_RELATIVE_JUMP
		|=> st_r.pc == 15'($past(st_r.pc) + 15'h0001 + {7'h00, $past(st_r.acc)}))
		else $error("accumulator jump target wrong");
	jump_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and jump_start) |=> $stable(st_r.flags))
		else $error("jump changed flags");
	bit_ops_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && (st_r.op == alu_pkg::OP_FILE_BIT_CLEAR
			|| st_r.op == alu_pkg::OP_FILE_BIT_SET) |=> $stable(st_r.flags))
		else $error("bit operation changed flags");
	bit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_FILE_BIT_CLEAR
		|=> st_r.result[$past(st_r.bitpos)] == 1'b0)
		else $error("bit clear left bit set");
	bit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_FILE_BIT_SET
		|=> st_r.result[$past(st_r.bitpos)] == 1'b1)
		else $error("bit set left bit clear");
	shift_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_ARITH_SHIFT_RIGHT_FILE
		|=> st_r.result[7] == st_r.result[6] && st_r.flags.ripple == $past(fval[0]))
		else $error("shift result or ripple wrong");
	null_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_ADD_ACC_TO_FILE
		|=> st_r.flags.null_res == (st_r.result == 8'h00))
		else $error("null flag disagrees with result");
	add_ripple_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_ADD_ACC_TO_FILE
		|=> st_r.flags.ripple == ({1'b0, $past(st_r.acc)} + {1'b0, $past(fval)} > 9'h0FF))
		else $error("ripple flag wrong after add");
	dest_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.phase == alu_pkg::ST_FIRST && !st_r.dest
		&& st_r.op == alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE |=> st_r.acc == st_r.result)
		else $error("accumulator not written for destination zero");

	// ----------------------------------------------------------------
	// Execution checks
	// ----------------------------------------------------------------
	// Carry-in that an addition is given, kept apart from the datapath function.
	wire logic chk_cin = st_r.op == alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE
		&& st_r.flags.ripple;

	sequence exec_add;
		st_r.phase == alu_pkg::ST_FIRST && (st_r.op == alu_pkg::OP_ADD_ACC_TO_FILE
			|| st_r.op == alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE);
	endsequence

	sequence exec_shift;
		st_r.phase == alu_pkg::ST_FIRST && st_r.op == alu_pkg::OP_ARITH_SHIFT_RIGHT_FILE;
	endsequence

	sequence exec_bit_op;
		st_r.phase == alu_pkg::ST_FIRST && (st_r.op == alu_pkg::OP_FILE_BIT_CLEAR
			|| st_r.op == alu_pkg::OP_FILE_BIT_SET);
	endsequence

	sequence idle_slot;
		st_r.phase == alu_pkg::ST_IDLE_CYCLE;
	endsequence

	sequence to_file;
		st_r.phase == alu_pkg::ST_FIRST && st_r.dest
			&& (st_r.op == alu_pkg::OP_ADD_ACC_TO_FILE
			|| st_r.op == alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE
			|| st_r.op == alu_pkg::OP_ARITH_SHIFT_RIGHT_FILE);
	endsequence

	add_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and exec_add) |=> st_r.result
			== 8'($past(st_r.acc) + $past(fval) + {7'h00, $past(chk_cin)}))
		else $error("sum of accumulator and file byte wrong");
	add_nibble_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and exec_add) |=> st_r.flags.nibble == ({1'b0, $past(st_r.acc[3:0])}
			+ {1'b0, $past(fval[3:0])} + {4'h0, $past(chk_cin)} > 5'h0F))
		else $error("nibble ripple flag wrong after add");
	add_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and exec_add) |=> st_r.flags.ripple == ({1'b0, $past(st_r.acc)}
			+ {1'b0, $past(fval)} + {8'h00, $past(chk_cin)} > 9'h0FF))
		else $error("ripple flag wrong after add with carry-in");
	dest_file_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and to_file) |=> file_mem[$past(st_r.addr)] == st_r.result
			&& st_r.acc == $past(st_r.acc))
		else $error("file destination not written or accumulator disturbed");
	shift_body_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and exec_shift) |=> st_r.result == {$past(fval[7]), $past(fval[7:1])}
			&& st_r.flags.null_res == ($past(fval[7:1]) == 7'h00))
		else $error("shift result or null flag wrong");
	shift_nibble_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and exec_shift) |=> st_r.flags.nibble == $past(st_r.flags.nibble))
		else $error("shift changed nibble ripple flag");
	bit_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and exec_bit_op) |=> ((st_r.result ^ $past(fval))
			& ~(8'h01 << $past(st_r.bitpos))) == 8'h00
			&& file_mem[$past(st_r.addr)] == st_r.result && st_r.acc == $past(st_r.acc))
		else $error("bit operation disturbed other bits or missed the file");
	idle_noop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce and idle_slot) |=> st_r.phase == alu_pkg::ST_READY && $stable(st_r.pc)
			&& $stable(st_r.flags) && $stable(st_r.acc))
		else $error("idle cycle after a jump was not a no-operation");
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_r.ready |=> !st_r.ready)
		else $error("ready held for more than one cycle");
	ce_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(st_r))
		else $error("state moved while the clock enable was low");
	err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.err |-> st_r.ready)
		else $error("error flag raised without ready");
endmodule

// >>> verification/cmd_source.sv
// Purpose: Register-bus master standing in for the decoder that issues operations.
// Assumes: One clock; signals change only by non-blocking assignment after a rising edge.
// Notes:   Holds each request until pready is sampled high, then releases it.
`timescale 1ns/1ns
module cmd_source (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rdat;
	logic        rerr;

	initial begin
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 12'h000;
		pwdata  = 32'h00000000;
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		pwdata  <= ~d;
	endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the byte ALU and relative jump block.
// Assumes: Operands are loaded through the file window register before use.
// Notes:   Clock enable drops once mid-run to check that pready stays low for six cycles and the held write lands afterwards.
`timescale 1ns/1ns
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ce;
	int          mismatches;
	int          cmp_count;
	int          cyc;

	byte_alu_branch uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	cmd_source src (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	initial pclk = 1'h0;
	always #20 pclk = ~pclk;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		src.xfer(1'h1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e);
		src.xfer(1'h0, a, 32'h00000000);
		chk(nm, e, src.rdat);
	endtask

	function automatic logic [31:0] cmd(input alu_pkg::op_e op, input logic d,
		input logic [2:0] b, input logic [6:0] a, input logic [8:0] k);
		return {7'h00, k, 1'h0, a, b, d, op};
	endfunction

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		presetn = 1'h0;
		ce      = 1'h1;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		wr(alu_pkg::OFS_FILE, 32'h0000_0571);
		wr(alu_pkg::OFS_ACC, 32'h0000_008F);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_ADD_ACC_TO_FILE, 1'h0, 3'h0, 7'h05, 9'h000));
		rd(alu_pkg::OFS_ACC, "add acc", 32'h0000_0000);
		rd(alu_pkg::OFS_FLAGS, "add flags", 32'h0000_0007);
		rd(alu_pkg::OFS_FILE, "add file kept", 32'h0000_0571);
		wr(alu_pkg::OFS_ACC, 32'h0000_0012);
		wr(alu_pkg::OFS_FILE, 32'h0000_7F34);
		wr(alu_pkg::OFS_CMD,
			cmd(alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE, 1'h1, 3'h0, 7'h7F, 9'h000));
		rd(alu_pkg::OFS_FILE, "adc file", 32'h0000_7F47);
		rd(alu_pkg::OFS_ACC, "adc acc kept", 32'h0000_0012);
		rd(alu_pkg::OFS_FLAGS, "adc flags", 32'h0000_0000);
		wr(alu_pkg::OFS_FILE, 32'h0000_0381);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_ARITH_SHIFT_RIGHT_FILE, 1'h0, 3'h0, 7'h03, 9'h000));
		rd(alu_pkg::OFS_ACC, "asr acc", 32'h0000_00C0);
		rd(alu_pkg::OFS_FLAGS, "asr flags", 32'h0000_0001);
		wr(alu_pkg::OFS_FILE, 32'h0000_0401);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_ARITH_SHIFT_RIGHT_FILE, 1'h1, 3'h0, 7'h04, 9'h000));
		rd(alu_pkg::OFS_FILE, "asr file", 32'h0000_0400);
		rd(alu_pkg::OFS_FLAGS, "asr null", 32'h0000_0005);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_FILE_BIT_CLEAR, 1'h0, 3'h7, 7'h03, 9'h000));
		wr(alu_pkg::OFS_FILE, 32'h0000_0300);
		wr(alu_pkg::OFS_FILE, 32'h0000_0381);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_FILE_BIT_CLEAR, 1'h0, 3'h7, 7'h03, 9'h000));
		rd(alu_pkg::OFS_FILE, "bit clear", 32'h0000_0301);
		wr(alu_pkg::OFS_FILE, 32'h0000_0400);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_FILE_BIT_SET, 1'h0, 3'h6, 7'h04, 9'h000));
		rd(alu_pkg::OFS_FILE, "bit set", 32'h0000_0440);
		rd(alu_pkg::OFS_FLAGS, "bit flags", 32'h0000_0005);
		wr(alu_pkg::OFS_PC, 32'h0000_0100);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_LITERAL_RELATIVE_JUMP, 1'h0, 3'h0, 7'h00, 9'h100));
		rd(alu_pkg::OFS_PC, "jump back", 32'h0000_0001);
		wr(alu_pkg::OFS_PC, 32'h0000_7FFF);
		wr(alu_pkg::OFS_CMD, cmd(alu_pkg::OP_LITERAL_RELATIVE_JUMP, 1'h0, 3'h0, 7'h00, 9'h0FF));
		rd(alu_pkg::OFS_PC, "jump fwd", 32'h0000_00FF);
		wr(alu_pkg::OFS_ACC, 32'h0000_00FF);
		wr(alu_pkg::OFS_PC, 32'h0000_0010);
		wr(alu_pkg::OFS_CMD,
			cmd(alu_pkg::OP_ACCUMULATOR_RELATIVE_JUMP, 1'h0, 3'h0, 7'h00, 9'h000));
		rd(alu_pkg::OFS_PC, "jump acc", 32'h0000_0110);
		rd(alu_pkg::OFS_FLAGS, "jump flags", 32'h0000_0005);
		rd(alu_pkg::OFS_STATUS, "phase", 32'h0000_0000);
		wr(alu_pkg::OFS_CMD,
			cmd(alu_pkg::OP_ADD_ACC_FILE_WITH_RIPPLE, 1'h0, 3'h0, 7'h04, 9'h000));
		rd(alu_pkg::OFS_ACC, "adc to acc", 32'h0000_0040);
		rd(alu_pkg::OFS_FLAGS, "adc carry flags", 32'h0000_0003);
		rd(12'h01C, "unmapped data", 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0, src.rerr});
		ce <= 1'h0;
		fork
			wr(alu_pkg::OFS_ACC, 32'h0000_005A);
			begin
				repeat (6) begin
					@(posedge pclk);
					chk("frozen ready", 32'h0000_0000, {31'h0, pready});
				end
				ce <= 1'h1;
			end
		join
		rd(alu_pkg::OFS_ACC, "write after freeze", 32'h0000_005A);
		presetn <= 1'h0;
		@(posedge pclk);
		presetn <= 1'h1;
		rd(alu_pkg::OFS_ACC, "reset acc", 32'h0000_0000);
		rd(alu_pkg::OFS_FLAGS, "reset flags", 32'h0000_0000);
		rd(alu_pkg::OFS_PC, "reset pc", 32'h0000_0000);
		stop_test();
	end
endmodule
